/* File: verilog/ppd_core.sv */
// push-pull gate timing core: clock select, divider, dead time, drain enables
// assumes en_pin, ext_clk and supply_low are asynchronous pins; AXI4-Lite on aclk
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - enable low stops switching and holds the block idle
// - enable pin reads as disabled when undriven; flops reset to disabled
// - disabled or supply low tri-states both drain outputs
// - internal oscillator period is swept to spread switching energy
// - external clock rising edges toggle the divide-by-two stage
// - no external edge within the timeout returns to the internal oscillator
// - valid external clock turns off spread modulation
// - divider gives two complementary half-rate phases, equal halves unless spread modulation is on
// - both gates low for the dead time before either goes high
// - gates alternate; the two switches are never on together
// - drive level ramps up after power-up and each enable rise
module ppd_core
	import ppd_pkg::*;
#(
	parameter int SS_CYC = SS_RAMP_CYC
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic en_pin,
	input wire logic ext_clk,
	input wire logic supply_low,
	output logic gate_drive_a,
	output logic gate_drive_b,
	output logic drain_out_a_o,
	output logic drain_out_a_oe,
	output logic drain_out_b_o,
	output logic drain_out_b_oe,
	output logic [7:0] drive_level
);
	localparam int SS_STEP = (SS_CYC / LVL_STEPS > 0) ? SS_CYC / LVL_STEPS : 1;

	logic [3:0] ctrl_q;
	logic en_s1_q, en_s2_q;
	logic low_s1_q, low_s2_q;
	logic ck_s1_q, ck_s2_q, ck_s3_q;
	logic ext_rise;
	logic active;
	logic active_q;
	logic ext_valid_q;
	logic [15:0] ext_age_q;
	logic int_tick;
	logic sel_edge;
	logic pend_q;
	logic [7:0] half_cnt_q;
	logic phase_q;
	logic [7:0] lvl_q;
	logic [19:0] ss_cnt_q;
	logic oe_a_q, oe_b_q;
	logic aw_q, w_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [31:0] stat;

	ppd_phase_if ph ();

	// pin synchronisers; enable resets low so an unsampled enable means off, supply low resets high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_s1_q <= 1'b0;
			en_s2_q <= 1'b0;
			low_s1_q <= 1'b1;
			low_s2_q <= 1'b1;
			ck_s1_q <= 1'b0;
			ck_s2_q <= 1'b0;
			ck_s3_q <= 1'b0;
		end else begin
			en_s1_q <= en_pin;
			en_s2_q <= en_s1_q;
			low_s1_q <= supply_low;
			low_s2_q <= low_s1_q;
			ck_s1_q <= ext_clk;
			ck_s2_q <= ck_s1_q;
			ck_s3_q <= ck_s2_q;
		end
	end

	assign ext_rise = ck_s2_q & ~ck_s3_q;
	assign active = en_s2_q & ctrl_q[CTRL_SW_EN] & ~low_s2_q;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			active_q <= 1'b0;
		else
			active_q <= active;
	end

	// external clock watchdog, counted in aclk cycles
	always_ff @(posedge aclk) begin
		if (!aresetn || !active || !ctrl_q[CTRL_EXT_ALLOW]) begin
			ext_valid_q <= 1'b0;
			ext_age_q <= 16'h0000;
		end else if (ext_rise) begin
			ext_valid_q <= 1'b1;
			ext_age_q <= 16'h0000;
		end else if (ext_age_q >= 16'(EXT_TIMEOUT_CYC)) begin
			ext_valid_q <= 1'b0;
		end else begin
			ext_age_q <= ext_age_q + 16'h0001;
		end
	end

	ppd_spread_osc u_osc (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(active),
		.spread_on(ctrl_q[CTRL_SPREAD] & ~ext_valid_q),
		.tick(int_tick)
	);

	assign sel_edge = ext_valid_q ? ext_rise : int_tick;

	// an edge too soon after the last toggle waits, so a source swap cannot
	// shorten a half period; limits the external clock to the fastest internal rate
	always_ff @(posedge aclk) begin
		if (!aresetn || !active) begin
			pend_q <= 1'b0;
			half_cnt_q <= 8'h00;
			phase_q <= 1'b0;
		end else if ((sel_edge || pend_q) && half_cnt_q >= 8'(MIN_HALF_CYC - 1)) begin
			pend_q <= 1'b0;
			half_cnt_q <= 8'h00;
			phase_q <= ~phase_q;
		end else begin
			if (sel_edge)
				pend_q <= 1'b1;
			if (half_cnt_q != 8'hff)
				half_cnt_q <= half_cnt_q + 8'h01;
		end
	end

	assign ph.run = active_q;
	assign ph.phase = phase_q;

	ppd_dead_time u_dt (
		.aclk(aclk),
		.aresetn(aresetn),
		.ph(ph)
	);

	assign gate_drive_a = ph.gate_a;
	assign gate_drive_b = ph.gate_b;

	// drains only pull low; released whenever off, disabled or supply low
	always_ff @(posedge aclk) begin
		if (!aresetn || !active) begin
			oe_a_q <= 1'b0;
			oe_b_q <= 1'b0;
		end else begin
			oe_a_q <= ph.gate_a;
			oe_b_q <= ph.gate_b;
		end
	end

	assign drain_out_a_o = 1'b0;
	assign drain_out_b_o = 1'b0;
	assign drain_out_a_oe = oe_a_q;
	assign drain_out_b_oe = oe_b_q;

	// soft-start: restarts from zero whenever the block leaves the idle state
	always_ff @(posedge aclk) begin
		if (!aresetn || !active) begin
			lvl_q <= 8'h00;
			ss_cnt_q <= 20'h00000;
		end else if (!ctrl_q[CTRL_SOFT]) begin
			lvl_q <= 8'hff;
		end else if (lvl_q != 8'hff) begin
			if (ss_cnt_q >= 20'(SS_STEP - 1)) begin
				ss_cnt_q <= 20'h00000;
				lvl_q <= lvl_q + 8'h01;
			end else begin
				ss_cnt_q <= ss_cnt_q + 20'h00001;
			end
		end
	end

	assign drive_level = lvl_q;

	// AXI4-Lite write: address and data taken in either order
	assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_q & ~s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			awaddr_q <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (aw_q && w_q) begin
			aw_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (aw_q && w_q) begin
			w_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (aw_q && w_q) begin
			s_axi_bvalid <= 1'b1;
			if (awaddr_q[7:2] == ADDR_CTRL[7:2] || awaddr_q[7:2] == ADDR_STAT[7:2])
				s_axi_bresp <= RESP_OKAY;
			else
				s_axi_bresp <= RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_q <= CTRL_RST;
		else if (aw_q && w_q && awaddr_q[7:2] == ADDR_CTRL[7:2] && wstrb_q[0])
			ctrl_q <= wdata_q[CTRL_W-1:0];
	end

	always_comb begin
		stat = 32'h00000000;
		stat[STAT_ACTIVE] = active_q;
		stat[STAT_EXT] = ext_valid_q;
		stat[STAT_LOW] = low_s2_q;
		stat[STAT_EN] = en_s2_q;
		stat[STAT_PHASE] = phase_q;
		stat[STAT_LVL +: LVL_W] = lvl_q;
	end

	// AXI4-Lite read; status writes are accepted and ignored
	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			if (s_axi_araddr[7:2] == ADDR_CTRL[7:2]) begin
				s_axi_rdata <= {28'h0000000, ctrl_q};
				s_axi_rresp <= RESP_OKAY;
			end else if (s_axi_araddr[7:2] == ADDR_STAT[7:2]) begin
				s_axi_rdata <= stat;
				s_axi_rresp <= RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : ppd_core
`default_nettype wire

/* File: inc/ppd_pkg.sv */
// constants and types shared by the push-pull gate timing core
// assumes a 40 MHz aclk; all times are turned into aclk cycles here
package ppd_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int CLK_MHZ = 40;
	// register map, byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	// control fields
	localparam int CTRL_SW_EN = 0;
	localparam int CTRL_EXT_ALLOW = 1;
	localparam int CTRL_SPREAD = 2;
	localparam int CTRL_SOFT = 3;
	localparam int CTRL_W = 4;
	localparam logic [3:0] CTRL_RST = 4'hf;
	// status fields
	localparam int STAT_ACTIVE = 0;
	localparam int STAT_EXT = 1;
	localparam int STAT_LOW = 2;
	localparam int STAT_EN = 3;
	localparam int STAT_PHASE = 4;
	localparam int STAT_LVL = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// dead time: least time, rounded up
	localparam int DEAD_TIME_NS = 90;
	localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// internal oscillator, nominal 840 kHz after the divide by two
	localparam int INT_OSC_KHZ = 840;
	localparam int INT_HALF_CYC = (CLK_MHZ * 1000) / (2 * INT_OSC_KHZ);
	localparam int SPREAD_SPAN = 6;
	localparam int OSC_MIN_CYC = INT_HALF_CYC - SPREAD_SPAN / 2;
	// shortest accepted gap between divider toggles
	localparam int MIN_HALF_CYC = OSC_MIN_CYC;
	// external clock timeout, longest time, rounded down
	localparam int EXT_TIMEOUT_US = 50;
	localparam int EXT_TIMEOUT_CYC = EXT_TIMEOUT_US * CLK_MHZ;
	// soft-start ramp length; the top turns it into a parameter
	localparam int SS_TIME_US = 2000;
	localparam int SS_RAMP_CYC = SS_TIME_US * CLK_MHZ;
	localparam int LVL_W = 8;
	localparam int LVL_STEPS = 256;
endpackage : ppd_pkg

/* File: inc/ppd_phase_if.sv */
// phase and gate signals between the core and its dead-time stage
// assumes both ends share aclk
`timescale 1ns/1ps
`default_nettype none
interface ppd_phase_if;
	logic run;
	logic phase;
	logic gate_a;
	logic gate_b;
	modport src (output run, output phase, input gate_a, input gate_b);
	modport dt (input run, input phase, output gate_a, output gate_b);
endinterface : ppd_phase_if
`default_nettype wire

/* File: verilog/ppd_spread_osc.sv */
// internal oscillator with triangular period modulation
// assumes run and spread_on come from aclk-domain logic
`timescale 1ns/1ps
`default_nettype none
module ppd_spread_osc
	import ppd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic spread_on,
	output logic tick
);
	logic [7:0] cnt_q;
	logic [7:0] off_q;
	logic up_q;
	logic [7:0] half;

	// period walks the span up and down so the energy lands in several bins
	always_comb begin
		if (spread_on)
			half = 8'(OSC_MIN_CYC) + off_q;
		else
			half = 8'(INT_HALF_CYC);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_q <= 8'h00;
		end else if (cnt_q >= half - 8'h01) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			tick <= 1'b0;
		end else begin
			tick <= (cnt_q >= half - 8'h01);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !spread_on) begin
			off_q <= 8'h00;
			up_q <= 1'b1;
		end else if (cnt_q >= half - 8'h01) begin
			if (up_q && off_q == 8'(SPREAD_SPAN))
				up_q <= 1'b0;
			else if (!up_q && off_q == 8'h00)
				up_q <= 1'b1;
			else if (up_q)
				off_q <= off_q + 8'h01;
			else
				off_q <= off_q - 8'h01;
		end
	end
endmodule : ppd_spread_osc
`default_nettype wire

/* File: verilog/ppd_dead_time.sv */
// break-before-make stage between the phase and the two gate drives
// assumes phase changes no faster than once per DEAD_CYC cycles
`timescale 1ns/1ps
`default_nettype none
module ppd_dead_time
	import ppd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	ppd_phase_if.dt ph
);
	logic [3:0] gap_q;
	logic last_q;

	always_ff @(posedge aclk) begin
		if (!aresetn || !ph.run) begin
			gap_q <= 4'(DEAD_CYC);
			last_q <= 1'b0;
		end else if (ph.phase != last_q) begin
			gap_q <= 4'(DEAD_CYC);
			last_q <= ph.phase;
		end else if (gap_q != 4'h0) begin
			gap_q <= gap_q - 4'h1;
		end
	end

	// both gates drop at once on a phase change and the new one waits out the gap
	always_ff @(posedge aclk) begin
		if (!aresetn || !ph.run) begin
			ph.gate_a <= 1'b0;
			ph.gate_b <= 1'b0;
		end else if (ph.phase != last_q || gap_q != 4'h0) begin
			ph.gate_a <= 1'b0;
			ph.gate_b <= 1'b0;
		end else begin
			ph.gate_a <= last_q;
			ph.gate_b <= ~last_q;
		end
	end
endmodule : ppd_dead_time
`default_nettype wire

/* File: verification/ppd_core_assertions.sv */
// checker: gate timing, drain release and AXI4-Lite handshakes of ppd_core
// assumes it is bound to ppd_core and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ppd_core_chk
	import ppd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic en_pin,
	input wire logic supply_low,
	input wire logic gate_drive_a,
	input wire logic gate_drive_b,
	input wire logic drain_out_a_oe,
	input wire logic drain_out_b_oe
);
	// cycles with both gates low; may grow large while idle
	int lo_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || gate_drive_a || gate_drive_b) begin
			lo_q <= 0;
		end else begin
			lo_q <= lo_q + 1;
		end
	end
	// cycles with a gate high; a source swap must not cut this short
	int hi_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || !(gate_drive_a || gate_drive_b)) begin
			hi_q <= 0;
		end else begin
			hi_q <= hi_q + 1;
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// pins pass two sync flops, a state flop and the gate flop
	sequence idle_run;
		(!en_pin || supply_low) [*6];
	endsequence
	gate_excl_a: assert property (!(gate_drive_a && gate_drive_b))
		else $error("both gate drives high");
	dead_gap_a: assert property ($rose(gate_drive_a) || $rose(gate_drive_b) |-> lo_q >= DEAD_CYC)
		else $error("dead time too short");
	oe_follow_a: assert property ((drain_out_a_oe |-> $past(gate_drive_a))
		and (drain_out_b_oe |-> $past(gate_drive_b))) else $error("drain on without gate");
	idle_off_a: assert property (idle_run |-> !drain_out_a_oe && !drain_out_b_oe
		&& !gate_drive_a && !gate_drive_b) else $error("drain driven while off");
	half_min_a: assert property (($fell(gate_drive_a) || $fell(gate_drive_b)) && en_pin
		&& !supply_low |-> hi_q >= MIN_HALF_CYC - DEAD_CYC - 1) else $error("gate pulse too short");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("arready wrong");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	wr_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
endmodule : ppd_core_chk
bind ppd_core ppd_core_chk chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .en_pin, .supply_low, .gate_drive_a, .gate_drive_b,
	.drain_out_a_oe, .drain_out_b_oe);
`default_nettype wire

/* File: verification/ppd_switch_model.sv */
// model of the two power switches on the transformer primary
// assumes the drain enables come from ppd_core on aclk
`timescale 1ns/1ps
`default_nettype none
module ppd_switch_model (
	input wire logic aclk,
	input wire logic drain_out_a_o,
	input wire logic drain_out_a_oe,
	input wire logic drain_out_b_o,
	input wire logic drain_out_b_oe,
	output logic pin_a,
	output logic pin_b,
	output int overlap
);
	// a released drain is pulled up to the center-tap by the primary
	assign pin_a = drain_out_a_oe ? drain_out_a_o : 1'b1;
	assign pin_b = drain_out_b_oe ? drain_out_b_o : 1'b1;
	initial overlap = 0;
	// both switches on would short the primary
	always @(posedge aclk) begin
		if (drain_out_a_oe && drain_out_b_oe) begin
			overlap <= overlap + 1;
		end
	end
endmodule : ppd_switch_model
`default_nettype wire

/* File: verification/tb_pushpull_gate_timing_clock_select.sv */
// testbench: pins, external clock and AXI4-Lite of ppd_core
// assumes ppd_pkg, the interface, design, checker and switch model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_pushpull_gate_timing_clock_select
	import ppd_pkg::*;
;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, en_pin = 0, ext_clk = 0, supply_low = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rd_v, v;
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] rsp;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic gate_drive_a, gate_drive_b, drain_out_a_o, drain_out_a_oe, pin_a, pin_b;
	wire logic drain_out_b_o, drain_out_b_oe;
	wire logic [7:0] drive_level;
	int overlap, n_mismatch = 0, checks_done = 0, ext_half = 30, ecnt = 0, per, hi, hb, mn, mx;
	logic ext_run = 0;
	always #12.5 aclk = ~aclk;
	ppd_core #(.SS_CYC(512)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .en_pin, .ext_clk, .supply_low, .gate_drive_a, .gate_drive_b,
		.drain_out_a_o, .drain_out_a_oe, .drain_out_b_o, .drain_out_b_oe, .drive_level);
	ppd_switch_model sw (.aclk, .drain_out_a_o, .drain_out_a_oe, .drain_out_b_o, .drain_out_b_oe,
		.pin_a, .pin_b, .overlap);
	// external clock made from aclk, ext_half cycles per half; holds still while stopped
	always @(posedge aclk) begin
		if (ext_run && ecnt >= ext_half - 1) begin
			ecnt <= 0;
			ext_clk <= ~ext_clk;
		end else if (ext_run) begin
			ecnt <= ecnt + 1;
		end
	end
	function int exp_ext(input int h);
		return 4 * h;
	endfunction : exp_ext
	function logic in_band(input int p);
		return p >= 2 * OSC_MIN_CYC && p <= 2 * (OSC_MIN_CYC + SPREAD_SPAN);
	endfunction : in_band
	function logic gsel(input bit s);
		return s ? gate_drive_b : gate_drive_a;
	endfunction : gsel
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task finish_test;
		$display("mismatches %0d of %0d checks", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1;
		w = 1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 0;
				s_axi_awvalid <= 0;
			end
			if (w && s_axi_wready) begin
				w = 0;
				s_axi_wvalid <= 0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		s_axi_bready <= 1;
		@(posedge aclk);
		rsp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		s_axi_rready <= 1;
		@(posedge aclk);
		rd_v = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask : rd
	// period and high time of one gate, in aclk cycles
	task meas(input bit sel);
		per = 0;
		while (gsel(sel) !== 1'b0) @(posedge aclk);
		while (gsel(sel) !== 1'b1) @(posedge aclk);
		while (gsel(sel) === 1'b1) begin
			@(posedge aclk);
			per++;
		end
		hi = per;
		while (gsel(sel) !== 1'b1) begin
			@(posedge aclk);
			per++;
		end
	endtask : meas
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		finish_test;
	end
	initial begin
		void'($urandom(32'h58cc));
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(ADDR_CTRL);
		chk("ctrl reset", CTRL_RST, rd_v);
		rd(8'h08);
		chk("unmapped read", RESP_SLVERR, rsp);
		wr(8'h0c, 32'h0);
		chk("unmapped write", RESP_SLVERR, rsp);
		wr(ADDR_STAT, 32'hff);
		chk("stat write", RESP_OKAY, rsp);
		chk("pins idle", 2'b11, {pin_a, pin_b});
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			wr(ADDR_CTRL, v);
			rd(ADDR_CTRL);
			chk("ctrl rw", v[3:0], rd_v);
		end
		wr(ADDR_CTRL, 32'h3);
		en_pin <= 1;
		repeat (8) @(posedge aclk);
		chk("level no soft", 8'hff, drive_level);
		meas(0);
		chk("fixed period", 2 * INT_HALF_CYC, per);
		hb = hi;
		chk("gate high", INT_HALF_CYC - DEAD_CYC - 1, hb);
		@(posedge aclk);
		chk("drain a low", 0, pin_a);
		meas(1);
		chk("equal halves", hb, hi);
		@(posedge aclk);
		chk("drain b low", 0, pin_b);
		wr(ADDR_CTRL, 32'h7);
		mn = 999;
		mx = 0;
		for (int i = 0; i < 8; i++) begin
			meas(0);
			chk("spread band", 1, in_band(per));
			mn = per < mn ? per : mn;
			mx = per > mx ? per : mx;
		end
		chk("spread varies", 1, mx > mn);
		wr(ADDR_CTRL, 32'hf);
		en_pin <= 0;
		repeat (8) @(posedge aclk);
		chk("disabled pins", 2'b11, {pin_a, pin_b});
		en_pin <= 1;
		repeat (8) @(posedge aclk);
		chk("ramp starts", 1, drive_level < 8'hff);
		repeat (600) @(posedge aclk);
		chk("ramp ends", 8'hff, drive_level);
		supply_low <= 1;
		repeat (8) @(posedge aclk);
		chk("lockout pins", 2'b11, {pin_a, pin_b});
		supply_low <= 0;
		ext_half = 25 + $urandom % 16;
		ext_run <= 1;
		repeat (400) @(posedge aclk);
		rd(ADDR_STAT);
		chk("ext selected", 1, rd_v[STAT_EXT]);
		meas(0);
		chk("ext period", exp_ext(ext_half), per);
		ext_run <= 0;
		repeat (2100) @(posedge aclk);
		rd(ADDR_STAT);
		chk("ext dropped", 0, rd_v[STAT_EXT]);
		meas(0);
		chk("back internal", 1, in_band(per));
		chk("switch overlap", 0, overlap);
		finish_test;
	end
endmodule : tb_pushpull_gate_timing_clock_select
`default_nettype wire
